// File: hw/file_reg_arith_branch_exec.sv
// Executor for file-register arithmetic, OR and absolute branch
`timescale 1ns/1ps
`include "exec_params.svh"

// What this block does
// - The destination bit sends a result to the accumulator (0) or file register 0-127 (1).
// - Decrement-and-skip stores file minus one, keeps flags, and skips on a zero result.
// - A zero decrement-and-skip result puts a no-operation in the next slot, two cycles.
// - Increment-and-skip stores file plus one at the destination and keeps the flags.
// - A zero increment-and-skip result puts a no-operation in the next slot, two cycles.
// - The absolute branch loads its 11-bit immediate into program counter bits 10 to 0.
// - The absolute branch fills program counter bits 14 to 11 from upper latch bits 6 to 3.
// - The absolute branch always takes two cycles and changes no flag.
// - OR-literal ORs an 8-bit literal into the accumulator and updates the zero flag.
// - Plain increment writes file plus one to the destination, updates zero, never skips.
// - OR-with-file ORs accumulator and file into the destination and updates zero.
// - One instruction cycle lasts four input clock periods.
module file_reg_arith_branch_exec #(
	parameter int FILE_DEPTH = 128
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic [13:0]  instr_in,
	input  wire logic         latch_we,
	input  wire logic [6:0]   latch_din,
	input  wire logic [6:0]   dbg_addr,
	output logic      [14:0]  pc_r,
	output logic      [7:0]   acc_r,
	output logic              zero_r,
	output logic              tick_r,
	output logic              flush_r,
	output logic      [7:0]   dbg_data_r
);
	import exec_pkg::*;

	exec_if alu_bus ();

	phase_t      phase_r;
	logic [13:0] ir_r;
	logic [6:0]  latch_r;
	logic [7:0]  file_r [FILE_DEPTH];
	op_t         op_c;
	logic [6:0]  addr_c;
	logic        dest_c;
	logic        file_op_c;
	logic        skip_c;
	logic        branch_c;
	logic [14:0] pc_nxt;

	// Quarter counter
	// quarter count
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			phase_r <= ph_q1;
		else
		begin
			unique case (phase_r)
				ph_q1: phase_r <= ph_q2;
				ph_q2: phase_r <= ph_q3;
				ph_q3: phase_r <= ph_q4;
				ph_q4: phase_r <= ph_q1;
			endcase
		end
	end

	// Registered so the boundary marker leaves straight from a flop
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			tick_r <= 1'b0;
		else
			tick_r <= (phase_r == ph_q3);
	end

	// Opcode decode; unknown words behave as no-operation
	always_comb
	begin
		if (ir_r[`EXEC_OPC_MSB:`EXEC_BR_LSB] == `EXEC_OPC_BRANCH)
			op_c = op_branch;
		else if (ir_r[`EXEC_OPC_MSB:`EXEC_OPC_LSB] == `EXEC_OPC_DECSKIP)
			op_c = op_decskip;
		else if (ir_r[`EXEC_OPC_MSB:`EXEC_OPC_LSB] == `EXEC_OPC_INCSKIP)
			op_c = op_incskip;
		else if (ir_r[`EXEC_OPC_MSB:`EXEC_OPC_LSB] == `EXEC_OPC_INC_FILE)
			op_c = op_inc_file;
		else if (ir_r[`EXEC_OPC_MSB:`EXEC_OPC_LSB] == `EXEC_OPC_OR_FILE)
			op_c = op_or_file;
		else if (ir_r[`EXEC_OPC_MSB:`EXEC_OPC_LSB] == `EXEC_OPC_OR_LIT)
			op_c = op_or_lit;
		else
			op_c = op_idle;
	end

	assign addr_c    = ir_r[`EXEC_ADDR_MSB:0];
	assign dest_c    = ir_r[`EXEC_DEST_BIT];
	assign file_op_c = (op_c == op_decskip) || (op_c == op_incskip)
		|| (op_c == op_inc_file) || (op_c == op_or_file);
	assign branch_c  = (op_c == op_branch);
	assign skip_c    = ((op_c == op_decskip) || (op_c == op_incskip)) && alu_bus.zero;

	assign alu_bus.op   = op_c;
	assign alu_bus.acc  = acc_r;
	assign alu_bus.fval = file_r[addr_c];
	assign alu_bus.lit  = ir_r[`EXEC_LIT_MSB:0];

	exec_alu u_alu (
		.bus (alu_bus.alu)
	);

	// Upper latch loaded from outside
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			latch_r <= `EXEC_LATCH_RST;
		else if (latch_we)
			latch_r <= latch_din;
	end

	always_comb
	begin
		if (branch_c)
			pc_nxt = {latch_r[`EXEC_LATCH_HI:`EXEC_LATCH_LO], ir_r[`EXEC_K_MSB:0]};
		else
			pc_nxt = pc_r + 15'h0001;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			pc_r <= `EXEC_PC_RST;
		else if (tick_r)
			pc_r <= pc_nxt;
	end

	// Prefetched word is squashed on skip or branch, costing one cycle
	// squash next
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ir_r    <= `EXEC_IDLE_WORD;
			flush_r <= 1'b0;
		end
		else if (tick_r)
		begin
			ir_r    <= (skip_c || branch_c) ? `EXEC_IDLE_WORD : instr_in;
			flush_r <= skip_c || branch_c;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			acc_r <= `EXEC_ACC_RST;
		else if (tick_r && ((file_op_c && !dest_c) || (op_c == op_or_lit)))
			acc_r <= alu_bus.result;
	end

	// Skip forms and branch leave the flag alone
	// zero update
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			zero_r <= 1'b0;
		else if (tick_r && ((op_c == op_inc_file) || (op_c == op_or_file)
			|| (op_c == op_or_lit)))
			zero_r <= alu_bus.zero;
	end

	for (genvar i = 0; i < FILE_DEPTH; i++)
	begin : g_file
		always_ff @(posedge clk or posedge sys_rst)
		begin
			if (sys_rst)
				file_r[i] <= `EXEC_FILE_RST;
			else if (tick_r && file_op_c && dest_c && (addr_c == 7'(i)))
				file_r[i] <= alu_bus.result;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			dbg_data_r <= 8'h00;
		else
			dbg_data_r <= file_r[dbg_addr];
	end

	property p_dest_acc;
		@(posedge clk) disable iff (sys_rst)
		tick_r && file_op_c && !dest_c |=> acc_r == $past(alu_bus.result);
	endproperty
	a_dest_acc: assert property (p_dest_acc) else $error("acc not written");

	property p_dest_file;
		@(posedge clk) disable iff (sys_rst)
		tick_r && file_op_c && dest_c |=> acc_r == $past(acc_r);
	endproperty
	a_dest_file: assert property (p_dest_file) else $error("acc changed");

	// Sparing the accumulator is not enough; the entry itself must take the result
	property p_dest_write;
		@(posedge clk) disable iff (sys_rst)
		tick_r && file_op_c && dest_c |=> file_r[$past(addr_c)] == $past(alu_bus.result);
	endproperty
	a_dest_write: assert property (p_dest_write) else $error("file not written");

	property p_dec_skip;
		@(posedge clk) disable iff (sys_rst)
		tick_r && op_c == op_decskip && alu_bus.fval == 8'h01
		|=> flush_r && zero_r == $past(zero_r) ##3 tick_r && op_c == op_idle;
	endproperty
	a_dec_skip: assert property (p_dec_skip) else $error("dec skip wrong");

	property p_dec_noskip;
		@(posedge clk) disable iff (sys_rst)
		tick_r && op_c == op_decskip && alu_bus.fval != 8'h01 |=> !flush_r;
	endproperty
	a_dec_noskip: assert property (p_dec_noskip) else $error("bad skip");

	// Squashed slot holds the idle word until the next boundary
	property p_flush_idle;
		@(posedge clk) disable iff (sys_rst)
		flush_r |-> op_c == op_idle;
	endproperty
	a_flush_idle: assert property (p_flush_idle) else $error("squash not idle");

	property p_inc_skip;
		@(posedge clk) disable iff (sys_rst)
		tick_r && op_c == op_incskip && alu_bus.fval == 8'hff
		|=> flush_r && zero_r == $past(zero_r);
	endproperty
	a_inc_skip: assert property (p_inc_skip) else $error("inc skip wrong");

	property p_inc_noflag;
		@(posedge clk) disable iff (sys_rst)
		tick_r && op_c == op_incskip |=> zero_r == $past(zero_r);
	endproperty
	a_inc_noflag: assert property (p_inc_noflag) else $error("flag changed");

	property p_branch_pc;
		@(posedge clk) disable iff (sys_rst)
		tick_r && branch_c |=> pc_r == {$past(latch_r[6:3]), $past(ir_r[10:0])};
	endproperty
	a_branch_pc: assert property (p_branch_pc) else $error("branch target");

	property p_latch_load;
		@(posedge clk) disable iff (sys_rst)
		latch_we |=> latch_r == $past(latch_din);
	endproperty
	a_latch_load: assert property (p_latch_load) else $error("latch not loaded");

	property p_branch_two;
		@(posedge clk) disable iff (sys_rst)
		tick_r && branch_c |=> flush_r && zero_r == $past(zero_r) ##3 tick_r && op_c == op_idle;
	endproperty
	a_branch_two: assert property (p_branch_two) else $error("branch cycles");

	property p_or_lit;
		@(posedge clk) disable iff (sys_rst)
		tick_r && op_c == op_or_lit
		|=> acc_r == ($past(acc_r) | $past(ir_r[7:0])) && zero_r == (acc_r == 8'h00);
	endproperty
	a_or_lit: assert property (p_or_lit) else $error("or literal");

	property p_inc_z;
		@(posedge clk) disable iff (sys_rst)
		tick_r && op_c == op_inc_file
		|=> !flush_r && zero_r == ($past(alu_bus.fval) == 8'hff);
	endproperty
	a_inc_z: assert property (p_inc_z) else $error("increment flag");

	property p_or_file;
		@(posedge clk) disable iff (sys_rst)
		tick_r && op_c == op_or_file
		|=> zero_r == (($past(acc_r) | $past(alu_bus.fval)) == 8'h00);
	endproperty
	a_or_file: assert property (p_or_file) else $error("or file flag");

	property p_cycle;
		@(posedge clk) disable iff (sys_rst)
		tick_r |=> !tick_r ##1 !tick_r ##1 !tick_r ##1 tick_r;
	endproperty
	a_cycle: assert property (p_cycle) else $error("cycle not four clocks");

	property p_single;
		@(posedge clk) disable iff (sys_rst)
		tick_r && !skip_c && !branch_c |=> !flush_r && pc_r == $past(pc_r) + 15'h0001;
	endproperty
	a_single: assert property (p_single) else $error("single cycle");

	c_branch: cover property (@(posedge clk) disable iff (sys_rst) tick_r && branch_c);
	c_dec_skip: cover property (@(posedge clk) disable iff (sys_rst)
		tick_r && op_c == op_decskip && skip_c);
	c_inc_skip: cover property (@(posedge clk) disable iff (sys_rst)
		tick_r && op_c == op_incskip && skip_c);
	c_or_lit: cover property (@(posedge clk) disable iff (sys_rst) tick_r && op_c == op_or_lit);
endmodule

// File: hw/exec_params.svh
// Constants for the file-register arithmetic and branch executor
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH
`define EXEC_QUARTERS     4
`define EXEC_PC_RST       15'h0000
`define EXEC_ACC_RST      8'h00
`define EXEC_FILE_RST     8'h00
`define EXEC_LATCH_RST    7'h00
`define EXEC_IDLE_WORD    14'h0000
`define EXEC_OPC_MSB      13
`define EXEC_OPC_LSB      8
`define EXEC_BR_LSB       11
`define EXEC_DEST_BIT     7
`define EXEC_ADDR_MSB     6
`define EXEC_LIT_MSB      7
`define EXEC_K_MSB        10
`define EXEC_LATCH_HI     6
`define EXEC_LATCH_LO     3
`define EXEC_OPC_DECSKIP  6'h01
`define EXEC_OPC_INCSKIP  6'h02
`define EXEC_OPC_INC_FILE 6'h03
`define EXEC_OPC_OR_FILE  6'h04
`define EXEC_OPC_OR_LIT   6'h05
`define EXEC_OPC_BRANCH   3'h7
`endif

// File: hw/exec_pkg.sv
// Types shared by the executor and its arithmetic unit
package exec_pkg;
	typedef enum logic [2:0] {
		op_idle     = 3'h0,
		op_decskip  = 3'h1,
		op_incskip  = 3'h2,
		op_inc_file = 3'h3,
		op_or_file  = 3'h4,
		op_or_lit   = 3'h5,
		op_branch   = 3'h6
	} op_t;
	typedef enum logic [1:0] {
		ph_q1 = 2'h0,
		ph_q2 = 2'h1,
		ph_q3 = 2'h2,
		ph_q4 = 2'h3
	} phase_t;
endpackage

// File: hw/exec_if.sv
// Operand and result bundle between the executor and its arithmetic unit
`timescale 1ns/1ps
interface exec_if;
	import exec_pkg::*;
	op_t        op;
	logic [7:0] acc;
	logic [7:0] fval;
	logic [7:0] lit;
	logic [7:0] result;
	logic       zero;
	modport core (output op, output acc, output fval, output lit, input result, input zero);
	modport alu (input op, input acc, input fval, input lit, output result, output zero);
endinterface

// File: hw/exec_alu.sv
// Combinational arithmetic unit for the executor
`timescale 1ns/1ps
module exec_alu (
	exec_if.alu bus
);
	import exec_pkg::*;

	always_comb
	begin
		unique case (bus.op)
			op_decskip: bus.result = bus.fval - 8'h01;
			op_incskip: bus.result = bus.fval + 8'h01;
			op_inc_file: bus.result = bus.fval + 8'h01;
			op_or_file:  bus.result = bus.acc | bus.fval;
			op_or_lit:   bus.result = bus.acc | bus.lit;
			op_idle:     bus.result = 8'h00;
			op_branch:  bus.result = 8'h00;
			default:    bus.result = 8'h00;
		endcase
	end

	// Zero test feeds both the flag and the skip decision
	assign bus.zero = (bus.result == 8'h00);
endmodule

// File: tb/file_reg_arith_branch_exec_test.sv
// Self-checking bench for the file-register executor
`timescale 1ns/1ps
`include "exec_params.svh"
module file_reg_arith_branch_exec_test;
	logic        clk;
	logic        sys_rst;
	logic [13:0] instr_in;
	logic        latch_we;
	logic [6:0]  latch_din;
	logic [6:0]  dbg_addr;
	logic [14:0] pc_r;
	logic [7:0]  acc_r;
	logic        zero_r;
	logic        tick_r;
	logic        flush_r;
	logic [7:0]  dbg_data_r;
	int          num_errors;
	int          check_count;
	int          mf[128];
	int          m_acc;
	int          m_z;
	int          m_pc;
	int          m_latch;
	int          m_flush;
	logic [13:0] m_held;
	logic [7:0]  rnd;
	bit          warm;
	logic [13:0] dir[$];
	logic [5:0]  ops[6];
	logic [13:0] w;

	file_reg_arith_branch_exec u_file_reg_arith_branch_exec (
		.clk(clk), .sys_rst(sys_rst), .instr_in(instr_in), .latch_we(latch_we),
		.latch_din(latch_din), .dbg_addr(dbg_addr), .pc_r(pc_r), .acc_r(acc_r),
		.zero_r(zero_r), .tick_r(tick_r), .flush_r(flush_r), .dbg_data_r(dbg_data_r)
	);

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction

	function automatic logic [13:0] fw(input logic [5:0] op, input logic d, input logic [6:0] a);
		return {op, d, a};
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
			begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("errors=%0d checks=%0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Model of one execute edge; old latch value feeds a branch
	task automatic model_exec();
		int a;
		int f;
		int r;
		int op;
		bit sq;
		a = m_held[6:0];
		f = mf[a];
		r = -1;
		sq = 1'b0;
		op = (m_held[13:11] == `EXEC_OPC_BRANCH) ? 0 : m_held[13:8];
		m_pc = (m_pc + 1) & 32767;
		if (m_held[13:11] == `EXEC_OPC_BRANCH)
			m_pc = (((m_latch >> 3) & 15) << 11) | m_held[10:0];
		sq = (m_held[13:11] == `EXEC_OPC_BRANCH);
		case (op)
			`EXEC_OPC_DECSKIP: r = (f + 255) & 255;
			`EXEC_OPC_INCSKIP: r = (f + 1) & 255;
			`EXEC_OPC_INC_FILE: r = (f + 1) & 255;
			`EXEC_OPC_OR_FILE: r = m_acc | f;
			`EXEC_OPC_OR_LIT: m_acc = m_acc | m_held[7:0];
			default: ;
		endcase
		if (op == `EXEC_OPC_DECSKIP || op == `EXEC_OPC_INCSKIP)
			sq = (r == 0);
		if (op == `EXEC_OPC_INC_FILE || op == `EXEC_OPC_OR_FILE)
			m_z = (r == 0);
		if (op == `EXEC_OPC_OR_LIT)
			m_z = (m_acc == 0);
		if (r >= 0 && m_held[7])
			mf[a] = r;
		else if (r >= 0)
			m_acc = r;
		m_held = sq ? `EXEC_IDLE_WORD : instr_in;
		m_flush = sq;
		if (latch_we)
			m_latch = latch_din;
	endtask

	// Present one word at the next execute edge, then compare
	task automatic step(input logic [13:0] wd, input logic we);
		int n;
		n = 0;
		while (tick_r !== 1'b1 && n < 20)
			begin
			@(posedge clk);
			#1;
			n++;
		end
		if (warm)
			check(16'(n), 16'h0002);
		rnd = lfsr(rnd);
		instr_in = wd;
		dbg_addr = wd[6:0];
		latch_we = we;
		latch_din = rnd[6:0];
		@(posedge clk);
		model_exec();
		#1;
		latch_we = 1'b0;
		check(16'(pc_r), 16'(m_pc));
		check(16'(acc_r), 16'(m_acc));
		check(16'(zero_r), 16'(m_z));
		check(16'(flush_r), 16'(m_flush));
		@(posedge clk);
		#1;
		check(16'(dbg_data_r), 16'(mf[wd[6:0]]));
		warm = 1'b1;
	endtask

	initial
	begin
		#20000;
		num_errors++;
		finish_test();
	end

	initial
	begin
		sys_rst = 1'b1;
		instr_in = 14'h0000;
		latch_we = 1'b0;
		latch_din = 7'h00;
		dbg_addr = 7'h00;
		num_errors = 0;
		check_count = 0;
		rnd = 8'h1c;
		m_acc = 0;
		m_z = 0;
		m_pc = 0;
		m_latch = 0;
		m_flush = 0;
		m_held = `EXEC_IDLE_WORD;
		ops = '{`EXEC_OPC_DECSKIP, `EXEC_OPC_INCSKIP, `EXEC_OPC_INC_FILE,
			`EXEC_OPC_OR_FILE, `EXEC_OPC_OR_LIT, 6'h00};
		repeat (12) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		// Zero results at the boundary address, then a branch to 7ff that squashes the branch to 000 behind it
		dir = '{fw(`EXEC_OPC_OR_LIT, 1'b0, 7'h00), fw(`EXEC_OPC_OR_LIT, 1'b0, 7'h01),
			fw(`EXEC_OPC_OR_FILE, 1'b1, 7'h7f), fw(`EXEC_OPC_DECSKIP, 1'b1, 7'h7f),
			fw(`EXEC_OPC_INC_FILE, 1'b0, 7'h7f), fw(`EXEC_OPC_INCSKIP, 1'b0, 7'h7f),
			fw(`EXEC_OPC_OR_LIT, 1'b1, 7'h7f), fw(`EXEC_OPC_OR_FILE, 1'b1, 7'h05),
			fw(`EXEC_OPC_INCSKIP, 1'b1, 7'h05), fw(`EXEC_OPC_INC_FILE, 1'b1, 7'h05),
			fw(`EXEC_OPC_DECSKIP, 1'b0, 7'h05), {3'h7, 11'h7ff}, {3'h7, 11'h000},
			fw(`EXEC_OPC_INC_FILE, 1'b0, 7'h09), fw(`EXEC_OPC_INC_FILE, 1'b1, 7'h09)};
		foreach (dir[i])
			step(dir[i], 1'b1);
		// Few addresses so that counts wrap and results collide
		repeat (300)
			begin
			rnd = lfsr(rnd);
			w = (rnd[2:0] > 3'h5) ? {3'h7, rnd[5:3], lfsr(rnd)} :
				fw(ops[rnd[2:0]], rnd[7], 7'(lfsr(rnd) & 8'h47));
			step(w, rnd[6]);
		end
		finish_test();
	end
endmodule
